// *** rtl/rwl_delay_timer.sv ***
`default_nettype none
// Pickup and dropout timer counted in processing ticks.
module rwl_delay_timer #(
  parameter int W = 16
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Timer input and settings.
  input wire logic tick,
  input wire logic din,
  input wire logic [W-1:0] pu_cnt,
  input wire logic [W-1:0] do_cnt,
  // Timed output.
  output logic dout
);
  logic [W-1:0] cnt;
  logic [W:0] lim;

  assign lim = {1'b0, din ? pu_cnt : do_cnt};

  // A disagreement must last the whole setting; any agreement restarts it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= '0;
      dout <= 1'b0;
    end else if (tick) begin
      if (din == dout) begin
        cnt <= '0;
      end else if (({1'b0, cnt} + 1'b1) >= lim) begin
        cnt <= '0;
        dout <= din;
      end else begin
        cnt <= cnt + 1'b1;
      end
    end
  end
endmodule // rwl_delay_timer
`default_nettype wire

// *** rtl/rwl_pkg.sv ***
`default_nettype none
// ----------------------------------------
// Constants of the relay word logic block.
// ----------------------------------------
package rwl_pkg;
  // Register indices; byte address is four times the index.
  localparam int REG_CTRL = 0;
  localparam int REG_CMD = 1;
  localparam int REG_STAT_LO = 2;
  localparam int REG_STAT_HI = 3;
  localparam int REG_TGT = 4;
  localparam int REG_ORV = 5;
  localparam int REG_SMASK = 14;
  localparam int REG_KMASK = 15;
  localparam int REG_LMASK = 16;
  localparam int REG_AND = 17;
  localparam int REG_TMR = 22;
  localparam int REG_CLOSE_IN = 25;
  localparam int REG_OUT = 26;
  localparam int NREG = 36;
  // Writable bits per register; rows outside an equation stay zero.
  localparam logic [31:0] WMASK [NREG] = '{
    32'h0000_0007, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
    32'h0000_0000, 32'h0000_ffff, 32'h0000_ffff, 32'h0000_ffff,
    32'h0000_ffff, 32'hffff_0000, 32'hffff_0000, 32'hffff_0000,
    32'hffff_0000, 32'hffff_ffff, 32'h00ff_ffff, 32'hffff_ffff,
    32'hffff_ffff, 32'h0000_07ff, 32'h0000_07ff, 32'h0000_07ff,
    32'h0000_07ff, 32'h0000_07ff, 32'hffff_ffff, 32'hffff_ffff,
    32'hffff_ffff, 32'h0000_ffff, 32'hff00_ffff, 32'h0000_ff00,
    32'hffff_ffff, 32'h0000_0000, 32'hffff_ffff, 32'h0000_0000,
    32'hffff_00ff, 32'h0000_ff00, 32'hffff_ff00, 32'h0000_ff00};
  // Control and command bits.
  localparam int CTRL_AUX4_ALARM = 0;
  localparam int CTRL_DT_ASSIGNED = 1;
  localparam int CTRL_CLOSE_ASSIGNED = 2;
  localparam int CMD_OPEN = 0;
  localparam int CMD_CLOSE = 1;
  localparam int CMD_TGT_RESET = 2;
  // Default logic states of unassigned input functions.
  localparam logic DT_DEFAULT = 1'b0;
  localparam logic CLOSE_DEFAULT = 1'b0;
  // Status word bit positions.
  localparam int W_OPTO6 = 22;
  localparam int W_OPTO5 = 23;
  localparam int W_ROW3_DLY = 30;
  localparam int W_TRIP = 31;
  localparam int W_AND_LO = 32;
  localparam int W_J = 40;
  localparam int W_ROW4_DLY = 41;
  localparam int W_NOT_L = 42;
  localparam int W_V = 43;
  localparam int W_AND_DLY = 47;
  // Timing.
  localparam int CLK_NS = 5;
  localparam int PROC_NS = 1_000_000;
  localparam int ONE_SEC_NS = 1_000_000_000;
  localparam int PROC_CYC = PROC_NS / CLK_NS;
  localparam int ONE_SEC_CYC = ONE_SEC_NS / CLK_NS;
  localparam int LVL1_TRIES = 3;
endpackage : rwl_pkg
`default_nettype wire

// *** rtl/rwl_pulse_stretch.sv ***
`default_nettype none
// Holds its output for LEN cycles after the last trigger.
module rwl_pulse_stretch #(
  parameter int LEN = 200_000_000
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Trigger and stretched level.
  input wire logic trig,
  output logic pulse
);
  logic [31:0] cnt;

  // A new trigger restarts the full length.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= '0;
      pulse <= 1'b0;
    end else if (trig) begin
      cnt <= 32'(LEN - 1);
      pulse <= 1'b1;
    end else if (cnt != 32'h0000_0000) begin
      cnt <= cnt - 1'b1;
    end else begin
      pulse <= 1'b0;
    end
  end
endmodule // rwl_pulse_stretch
`default_nettype wire

// *** rtl/rwl_relay_logic.sv ***
`default_nettype none
// Function
// RULE1: Keep a 48-bit status word of six rows, eight bits each.
// RULE2: Variables A-D OR rows 1-2, E-H OR rows 3-4, J ORs rows 1-4.
// RULE3: Row-three delay output comes from a timer fed by OR of rows 1-3.
// RULE4: Second delayed bit comes from a timer fed by OR of rows 1-4.
// RULE5: Each of the three timers has settable pickup and dropout delays.
// RULE6: An OR of rows 1-4 enters the word only inverted.
// RULE7: V, W, X, Y are user AND terms of A through the inverted term.
// RULE8: Last row-six bit is a timer fed by an AND term over A to !L.
// RULE9: Two word bits follow isolated inputs five and six directly.
// RULE10: The word's trip bit follows the trip output.
// RULE11: Trip is an OR of rows 1,2,4,6, plus direct trip or open command.
// RULE12: Aux outputs one and two are OR terms of rows 1-4.
// RULE13: Aux output three is an OR term of rows 1,3,4,6.
// RULE14: Aux four ORs rows 2,3,4,6, or acts as a second alarm.
// RULE15: Close asserts on direct close input or close command.
// RULE16: Alarm pulses 1 s on access and some self-test faults; others hold.
// RULE17: Alarm pulses on setting, group, password change or year mismatch.
// RULE18: Close-in target set only if no row-one bit outlasted the window.
// RULE19: Trip lights phase, negative-sequence and residual targets over pickup.
// RULE20: Targets stay latched until trip drops and a reset event occurs.
// RULE21: A new trip clears targets, then latches the new ones.
// RULE22: Target reset press lights all eight lamps for one second.
// RULE23: Unassigned input functions take their default state.
// RULE24: Everything is evaluated once per processing tick; timers count ticks. Alarm, lamps and button target reset act on every clock.
module rwl_relay_logic
  import rwl_pkg::*;
#(
  parameter int TICK_CYC = PROC_CYC,
  parameter int SEC_CYC = ONE_SEC_CYC
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Protection elements and inputs.
  input wire logic [7:0] elem_r1,
  input wire logic [7:0] elem_r2,
  input wire logic [5:0] elem_r3,
  input wire logic [5:0] elem_r4,
  input wire logic opto_five_bit,
  input wire logic opto_six_bit,
  input wire logic direct_trip_input,
  input wire logic direct_close_input,
  // Pickup comparisons for targets.
  input wire logic [2:0] phase_toc_pickup,
  input wire logic negseq_toc_pickup,
  input wire logic resid_toc_pickup,
  // Alarm events and front panel.
  input wire logic lvl1_fail,
  input wire logic lvl2_try,
  input wire logic selftest_pulse_fail,
  input wire logic selftest_hold_fail,
  input wire logic group_change,
  input wire logic pass_change,
  input wire logic year_mismatch,
  input wire logic tgt_reset_btn,
  // Contacts and lamps.
  output logic trip_out,
  output logic close_out,
  output logic aux_out_1,
  output logic aux_out_2,
  output logic aux_out_3,
  output logic aux_out_4,
  output logic alarm_out,
  output logic [7:0] led
);
  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic [31:0] cfg [NREG];
  logic [47:0] word;
  logic [31:0] lo;
  logic [10:0] av;
  logic [8:0] orv;
  logic [3:0] andv;
  logic [4:0] outv;
  logic [31:0] tick_cnt;
  logic tick;
  logic wr_en;
  logic rd_en;
  logic [5:0] idx;
  logic bad_addr;
  logic open_req;
  logic close_req;
  logic rst_req;
  logic [2:0] dly_in;
  logic l_or;
  logic [2:0] dly_out;
  logic dt_eff;
  logic close_pin_eff;
  logic next_trip;
  logic trip_rise;
  logic [15:0] r1_age;
  logic [5:0] tgt;
  logic [1:0] lvl1_cnt;
  logic lvl1_hit;
  logic alarm_trig;
  logic alarm_pulse;
  logic lamp;
  logic set_chg;
  logic hold_fail;

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  assign idx = paddr[7:2];
  assign bad_addr = (idx >= 6'(NREG)) || (paddr[1:0] != 2'b00);
  assign wr_en = psel && penable && pwrite && !bad_addr;
  assign rd_en = psel && !penable && !pwrite;

  // Zero-wait slave: every access completes in its first access cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && bad_addr;
    end
  end

  // Configuration storage; reserved bits never store.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NREG; i++) begin
        cfg[i] <= 32'h0000_0000;
      end
    end else if (wr_en) begin
      cfg[idx] <= pwdata & WMASK[idx];
    end
  end

  // Read data is prepared in the setup cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_en) begin
      if (bad_addr) begin
        prdata <= 32'h0000_0000;
      end else if (idx == 6'(REG_STAT_LO)) begin
        prdata <= word[31:0];
      end else if (idx == 6'(REG_STAT_HI)) begin
        prdata <= {16'h0000, word[47:32]};
      end else if (idx == 6'(REG_TGT)) begin
        prdata <= {24'h000000, led};
      end else begin
        prdata <= cfg[idx];
      end
    end
  end

  // Command bits are write-one pulses held until the next tick.
  // RULE11 open command
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      open_req <= 1'b0;
      close_req <= 1'b0;
      rst_req <= 1'b0;
    end else begin
      open_req <= (wr_en && idx == 6'(REG_CMD) && pwdata[CMD_OPEN]) || (open_req && !tick);
      close_req <= (wr_en && idx == 6'(REG_CMD) && pwdata[CMD_CLOSE]) || (close_req && !tick);
      rst_req <= (wr_en && idx == 6'(REG_CMD) && pwdata[CMD_TGT_RESET]) || (rst_req && !tick);
    end
  end

  // ----------------------------------------
  // Processing tick
  // ----------------------------------------
  // RULE24 fixed interval
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt <= '0;
      tick <= 1'b0;
    end else begin
      tick <= (tick_cnt == 32'(TICK_CYC - 1));
      tick_cnt <= (tick_cnt == 32'(TICK_CYC - 1)) ? '0 : tick_cnt + 1'b1;
    end
  end

  // ----------------------------------------
  // Logic equations
  // ----------------------------------------
  // Equations read the previous word, so feedback through the delayed bits and TRIP is one tick late.
  assign lo = word[31:0];
  assign av = word[W_NOT_L:W_AND_LO];

  // RULE2 OR variables
  for (genvar g = 0; g < 9; g++) begin : g_orv
    assign orv[g] = |(cfg[REG_ORV + g] & lo);
  end

  // RULE7 AND variables
  for (genvar g = 0; g < 4; g++) begin : g_andv
    assign andv[g] = (cfg[REG_AND + g][10:0] != 11'h000) &&
                     ((av & cfg[REG_AND + g][10:0]) == cfg[REG_AND + g][10:0]);
  end

  // RULE11 RULE12 output OR terms
  for (genvar g = 0; g < 5; g++) begin : g_outv
    assign outv[g] = |(cfg[REG_OUT + 2 * g] & lo) | |(cfg[REG_OUT + 2 * g + 1][15:0] & word[47:32]);
  end

  // RULE3 timer input
  assign dly_in[0] = |(cfg[REG_SMASK] & lo);
  // RULE4 timer input
  assign dly_in[1] = |(cfg[REG_KMASK] & lo);
  assign l_or = |(cfg[REG_LMASK] & lo);
  // RULE8 AND-driven timer input
  assign dly_in[2] = (cfg[REG_AND + 4][10:0] != 11'h000) &&
                     ((av & cfg[REG_AND + 4][10:0]) == cfg[REG_AND + 4][10:0]);

  // RULE23 unassigned defaults
  assign dt_eff = cfg[REG_CTRL][CTRL_DT_ASSIGNED] ? direct_trip_input : DT_DEFAULT;
  assign close_pin_eff = cfg[REG_CTRL][CTRL_CLOSE_ASSIGNED] ? direct_close_input : CLOSE_DEFAULT;

  // RULE11 trip equation
  assign next_trip = outv[0] || dt_eff || open_req;
  assign trip_rise = tick && next_trip && !trip_out;

  // RULE5 three timers
  for (genvar g = 0; g < 3; g++) begin : g_tmr
    rwl_delay_timer #(.W(16)) u_delay_timer (
      .pclk(pclk), .presetn(presetn), .tick(tick), .din(dly_in[g]),
      .pu_cnt(cfg[REG_TMR + g][15:0]), .do_cnt(cfg[REG_TMR + g][31:16]), .dout(dly_out[g]));
  end

  // Status word, trip, close and aux one to three contacts update together on each tick.
  // RULE1 status word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      word <= '0;
      trip_out <= 1'b0;
      close_out <= 1'b0;
      aux_out_1 <= 1'b0;
      aux_out_2 <= 1'b0;
      aux_out_3 <= 1'b0;
    end else if (tick) begin
      // RULE9 RULE10 RULE6 row assembly
      word <= {dly_out[2], andv[3:0], !l_or, dly_out[1], orv[8], orv[7:0],
               next_trip, dly_out[0], elem_r4,
               opto_five_bit, opto_six_bit, elem_r3[5:4], 1'b0, elem_r3[2:0],
               elem_r2, elem_r1};
      trip_out <= next_trip;
      // RULE15 close output
      close_out <= close_pin_eff || close_req;
      // RULE12 RULE13 aux outputs
      aux_out_1 <= outv[1];
      aux_out_2 <= outv[2];
      aux_out_3 <= outv[3];
    end
  end

  // ----------------------------------------
  // Alarm
  // ----------------------------------------
  // RULE17 settings change
  assign set_chg = wr_en && idx != 6'(REG_CMD);
  assign lvl1_hit = lvl1_fail && lvl1_cnt == 2'(LVL1_TRIES - 1);
  // RULE16 RULE17 pulse causes
  assign alarm_trig = lvl1_hit || lvl2_try || selftest_pulse_fail ||
                      set_chg || group_change || pass_change || year_mismatch;

  // Third failed first-level attempt fires the pulse and restarts the count.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lvl1_cnt <= 2'b00;
    end else if (lvl1_fail) begin
      lvl1_cnt <= lvl1_hit ? 2'b00 : lvl1_cnt + 1'b1;
    end
  end

  // RULE16 one-second pulse
  rwl_pulse_stretch #(.LEN(SEC_CYC)) u_alarm_stretch (
    .pclk(pclk), .presetn(presetn), .trig(alarm_trig), .pulse(alarm_pulse));

  // A hard self-test failure closes the alarm for good; only reset reopens it.
  // RULE16 permanent closure
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_fail <= 1'b0;
      alarm_out <= 1'b0;
      aux_out_4 <= 1'b0;
    end else begin
      hold_fail <= hold_fail || selftest_hold_fail;
      alarm_out <= alarm_pulse || hold_fail;
      // RULE14 aux four option
      if (cfg[REG_CTRL][CTRL_AUX4_ALARM]) begin
        aux_out_4 <= alarm_pulse || hold_fail;
      end else if (tick) begin
        aux_out_4 <= outv[4];
      end
    end
  end

  // ----------------------------------------
  // Targets
  // ----------------------------------------
  // RULE18 row-one age
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r1_age <= '0;
    end else if (tick) begin
      if (!(|word[7:0])) begin
        r1_age <= '0;
      end else if (r1_age != 16'hffff) begin
        r1_age <= r1_age + 1'b1;
      end
    end
  end

  // Bits: 5 close-in, 4..2 phases, 1 negative sequence, 0 residual.
  // RULE21 RULE19 RULE20 latch and clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tgt <= '0;
    end else if (trip_rise) begin
      tgt <= {r1_age <= cfg[REG_CLOSE_IN][15:0], phase_toc_pickup,
              negseq_toc_pickup, resid_toc_pickup};
    end else if (!trip_out && (tgt_reset_btn || (rst_req && tick))) begin
      tgt <= '0;
    end
  end

  // RULE22 lamp test
  rwl_pulse_stretch #(.LEN(SEC_CYC)) u_lamp_stretch (
    .pclk(pclk), .presetn(presetn), .trig(tgt_reset_btn), .pulse(lamp));

  // Lamps: 7 alarm, 6 enabled, 5..0 fault type.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      led <= 8'h00;
    end else begin
      led <= lamp ? 8'hff : {alarm_out, !hold_fail, tgt};
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  trip_bit_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE10
    word[W_TRIP] == trip_out) else $error("trip bit differs from trip output");
  opto_bits_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE9
    tick |=> word[W_OPTO5] == $past(opto_five_bit) && word[W_OPTO6] == $past(opto_six_bit))
    else $error("opto bits do not follow inputs");
  inv_term_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE6
    tick |=> word[W_NOT_L] == !$past(l_or)) else $error("inverted term wrong");
  and_empty_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE7
    tick && cfg[REG_AND][10:0] == 11'h000 |=> !word[W_V]) else $error("empty AND term set");
  close_out_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE15
    tick && close_pin_eff |=> close_out) else $error("close output missed");
  lamp_test_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE22
    tgt_reset_btn |=> ##1 led == 8'hff) else $error("lamp test missed");
  alarm_pulse_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE16
    lvl2_try |-> ##2 alarm_out) else $error("alarm pulse missed");
  tgt_capture_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE21
    trip_rise |=> tgt[0] == $past(resid_toc_pickup) && tgt[1] == $past(negseq_toc_pickup))
    else $error("targets not captured at trip");
  tgt_hold_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE20
    trip_out && !trip_rise |=> tgt == $past(tgt)) else $error("targets cleared during trip");
endmodule // rwl_relay_logic
`default_nettype wire

// *** verif/rwl_breaker_model.sv ***
`default_nettype none
// ----------------------------------------
// Breaker trip, close and alarm circuits.
// ----------------------------------------
module rwl_breaker_model #(
  parameter int OP_CYC = 3
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Contacts of the relay.
  input wire logic trip_out,
  input wire logic close_out,
  input wire logic alarm_out,
  // Breaker position and last alarm spell.
  output logic brk_closed,
  output logic [31:0] alarm_len
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] op_cnt;
  logic [31:0] run_len;
  // The mechanism moves only after OP_CYC cycles of coil energy; trip wins over close.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_cnt <= 8'h00;
      brk_closed <= 1'b0;
    end else if (trip_out || close_out) begin
      op_cnt <= op_cnt + 8'h01;
      if (op_cnt >= 8'(OP_CYC - 1)) brk_closed <= !trip_out;
    end else begin
      op_cnt <= 8'h00;
    end
  end
  // The alarm lamp circuit keeps the length of the last closed spell.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_len <= 32'h0;
      alarm_len <= 32'h0;
    end else if (alarm_out) begin
      run_len <= run_len + 32'h1;
    end else begin
      if (run_len != 32'h0) alarm_len <= run_len;
      run_len <= 32'h0;
    end
  end
endmodule // rwl_breaker_model
`default_nettype wire

// *** verif/rwl_relay_logic_tb_top.sv ***
`default_nettype none
// ----------------------------------------
// Self-checking bench of the relay word logic.
// ----------------------------------------
module rwl_relay_logic_tb_top
  import rwl_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int TN = 4;
  localparam int SC = 20;
  typedef struct {string n; logic [32:0] e; logic [32:0] m;} rwl_note_s;
  rwl_note_s q[$];
  rwl_note_s cur;
  logic [32:0] seen;
  int n_errors = 0;
  int num_checks = 0;
  int cyc = 0;
  int seed = 13136;
  logic [31:0] r;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, obs = 0;
  logic [7:0] paddr = 0, elem_r1 = 0, elem_r2 = 0;
  logic [31:0] pwdata = 0;
  logic [5:0] elem_r3 = 0, elem_r4 = 0, ev = 0;
  logic [2:0] phase_toc_pickup = 0;
  logic opto_five_bit = 0, opto_six_bit = 0, direct_trip_input = 0, direct_close_input = 0;
  logic negseq_toc_pickup = 0, resid_toc_pickup = 0, hold_fail = 0, tgt_reset_btn = 0;
  logic [31:0] prdata, alarm_len;
  logic pready, pslverr, trip_out, close_out, aux_out_1, aux_out_2, aux_out_3, aux_out_4, alarm_out;
  logic brk_closed;
  logic [7:0] led;
  // Short counts keep the run brief; every expectation below uses TN and SC.
  rwl_relay_logic #(.TICK_CYC(TN), .SEC_CYC(SC)) uut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .elem_r1, .elem_r2, .elem_r3, .elem_r4, .opto_five_bit, .opto_six_bit, .direct_trip_input,
    .direct_close_input, .phase_toc_pickup, .negseq_toc_pickup, .resid_toc_pickup,
    .lvl1_fail(ev[0]), .lvl2_try(ev[1]), .selftest_pulse_fail(ev[2]), .selftest_hold_fail(hold_fail),
    .group_change(ev[3]), .pass_change(ev[4]), .year_mismatch(ev[5]), .tgt_reset_btn,
    .trip_out, .close_out, .aux_out_1, .aux_out_2, .aux_out_3, .aux_out_4, .alarm_out, .led);
  rwl_breaker_model #(.OP_CYC(3)) far (
    .pclk, .presetn, .trip_out, .close_out, .alarm_out, .brk_closed, .alarm_len);
  // ----------------------------------------
  // Clock, checking and closing.
  // ----------------------------------------
  initial begin
    forever #2.5 pclk = ~pclk;
  end
  task automatic chk(input string n, input logic [32:0] s, input logic [32:0] e);
    num_checks++;
    if (s !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic end_of_test();
    if (n_errors == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // The oldest note is judged when a read completes or an observation strobe is sampled.
  always @(posedge pclk) begin
    if (obs || (psel && penable && pready === 1'b1 && !pwrite)) begin
      cur = q.size() > 0 ? q.pop_front() : '{"queue", 33'h1, 33'h1};
      seen = obs ? {alarm_len[24:0], brk_closed, alarm_out, aux_out_4, aux_out_3, aux_out_2, aux_out_1,
                    close_out, trip_out} : {pslverr, prdata};
      chk(cur.n, seen & cur.m, cur.e & cur.m);
    end
  end
  // A hang is cut short well beyond the expected length of the run.
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      n_errors++;
      end_of_test();
    end
  end
  // ----------------------------------------
  // Bus and observation tasks.
  // ----------------------------------------
  task automatic apb(input bit w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input int i, input logic [31:0] d);
    apb(1'b1, 8'(i * 4), d);
  endtask
  task automatic rd(input int i, input logic [32:0] e, input logic [32:0] m);
    q.push_back('{$sformatf("reg %0d", i), e, m});
    apb(1'b0, 8'(i * 4), 32'h0);
  endtask
  task automatic pins(input logic [32:0] e, input logic [32:0] m);
    q.push_back('{"contacts", e, m});
    @(posedge pclk);
    obs <= 1'b1;
    @(posedge pclk);
    obs <= 1'b0;
  endtask
  task automatic ticks(input int n);
    repeat (n * TN) @(posedge pclk);
  endtask
  task automatic pulse(input int k);
    ev <= 6'(1 << k);
    @(posedge pclk);
    ev <= 6'h0;
    @(posedge pclk);
  endtask
  // ----------------------------------------
  // Main sequence.
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    ticks(2);
    rd(REG_CTRL, 33'h0, '1);
    rd(REG_TGT, 33'h40, '1);
    rd(40, 33'h1_0000_0000, '1);
    q.push_back('{"unaligned", 33'h1_0000_0000, '1});
    apb(1'b0, 8'h09, 32'h0);
    wr(REG_STAT_LO, '1);
    rd(REG_STAT_LO, 33'h0, '1);
    rd(REG_STAT_HI, 33'h400, '1);
    // Random element and input patterns land in their word positions.
    for (int k = 0; k < 6; k++) begin
      r = $random(seed);
      {opto_six_bit, opto_five_bit, elem_r4, elem_r3, elem_r2, elem_r1} <= {r[31:24], r[21:0]};
      ticks(3);
      rd(REG_STAT_LO, {3'b000, r[29:24], r[30], r[31], r[21:16] & 6'h37, r[15:0]}, '1);
    end
    {opto_six_bit, opto_five_bit, elem_r4, elem_r3, elem_r2, elem_r1} <= '0;
    // Only the rows of each equation can be selected.
    for (int i = REG_ORV; i < NREG; i++) wr(i, '1);
    for (int i = REG_ORV; i < NREG; i++) rd(i, {1'b0, WMASK[i]}, '1);
    for (int i = REG_ORV; i < NREG; i++) wr(i, 32'h0);
    for (int i = 0; i < 8; i++) wr(REG_ORV + i, i < 4 ? 32'h1 : 32'h0100_0000);
    wr(REG_ORV + 8, 32'h100);
    wr(REG_LMASK, 32'h0100_0000);
    wr(REG_AND, 32'h401);
    elem_r1 <= 8'h01;
    ticks(4);
    rd(REG_STAT_HI, 33'hc0f, '1);
    elem_r4 <= 6'h01;
    ticks(4);
    rd(REG_STAT_HI, 33'h0ff, '1);
    elem_r2 <= 8'h01;
    ticks(4);
    rd(REG_STAT_HI, 33'h1ff, '1);
    {elem_r4, elem_r2, elem_r1} <= '0;
    // Each timer: pickup of 6 ticks, dropout of 10 ticks.
    for (int t = 0; t < 3; t++) begin
      wr(t == 2 ? REG_AND + 4 : REG_SMASK + t, t == 2 ? 32'h1 : 32'h2);
      wr(REG_TMR + t, {16'd10, 16'd6});
      elem_r1 <= 8'h03;
      ticks(2);
      rd(t == 0 ? REG_STAT_LO : REG_STAT_HI, 33'h0, t == 0 ? 33'h4000_0000 : 33'(1 << (t * 6 + 3)));
      ticks(8);
      rd(t == 0 ? REG_STAT_LO : REG_STAT_HI, '1, t == 0 ? 33'h4000_0000 : 33'(1 << (t * 6 + 3)));
      elem_r1 <= 8'h00;
      ticks(4);
      rd(t == 0 ? REG_STAT_LO : REG_STAT_HI, '1, t == 0 ? 33'h4000_0000 : 33'(1 << (t * 6 + 3)));
      ticks(10);
      rd(t == 0 ? REG_STAT_LO : REG_STAT_HI, 33'h0, t == 0 ? 33'h4000_0000 : 33'(1 << (t * 6 + 3)));
    end
    // Direct inputs count only when assigned; commands move the breaker.
    {direct_trip_input, direct_close_input} <= 2'b11;
    ticks(2);
    pins(33'h0, 33'h3);
    wr(REG_CTRL, 32'h6);
    ticks(2);
    pins(33'h3, 33'h3);
    {direct_trip_input, direct_close_input} <= 2'b00;
    wr(REG_CTRL, 32'h0);
    wr(REG_CMD, 32'h2);
    ticks(3);
    pins(33'h80, 33'h83);
    wr(REG_CMD, 32'h1);
    ticks(3);
    pins(33'h0, 33'h81);
    // Auxiliary equations, then the fourth output as a second alarm.
    wr(REG_OUT + 2, 32'h8);
    wr(REG_OUT + 4, 32'h1_0000);
    wr(REG_OUT + 7, 32'h100);
    wr(REG_OUT + 8, 32'h100);
    elem_r1 <= 8'h08;
    ticks(3);
    pins(33'h04, 33'h3c);
    {elem_r3, elem_r1} <= {6'h01, 8'h00};
    ticks(3);
    pins(33'h08, 33'h3c);
    {elem_r3, elem_r2} <= {6'h00, 8'h01};
    ticks(3);
    pins(33'h30, 33'h3c);
    elem_r2 <= 8'h00;
    wr(REG_CTRL, 32'h1);
    ticks(2);
    pins(33'h60, 33'h60);
    ticks(SC / TN + 3);
    pins(33'h0, 33'h60);
    wr(REG_CTRL, 32'h0);
    // Targets: capture, hold, replacement by a new trip, clearing.
    wr(REG_OUT, 32'h4);
    wr(REG_CLOSE_IN, 32'd3);
    {phase_toc_pickup, negseq_toc_pickup, resid_toc_pickup} <= 5'b101_10;
    elem_r1 <= 8'h04;
    ticks(2);
    pins(33'h1, 33'h1);
    rd(REG_STAT_LO, 33'h8000_0000, 33'h8000_0000);
    rd(REG_TGT, 33'h36, 33'h3f);
    {phase_toc_pickup, negseq_toc_pickup} <= 4'b000_0;
    wr(REG_CMD, 32'h4);
    ticks(2);
    rd(REG_TGT, 33'h36, 33'h3f);
    elem_r1 <= 8'h01;
    phase_toc_pickup <= 3'b010;
    ticks(6);
    rd(REG_TGT, 33'h36, 33'h3f);
    elem_r1 <= 8'h05;
    ticks(2);
    rd(REG_TGT, 33'h08, 33'h3f);
    elem_r1 <= 8'h00;
    ticks(2);
    wr(REG_CMD, 32'h4);
    ticks(2);
    rd(REG_TGT, 33'h0, 33'h3f);
    tgt_reset_btn <= 1'b1;
    @(posedge pclk);
    tgt_reset_btn <= 1'b0;
    ticks(1);
    rd(REG_TGT, 33'hff, '1);
    ticks(SC / TN + 2);
    rd(REG_TGT, 33'h0, 33'h3f);
    // Alarm pulses: the third level one failure, then every other event.
    repeat (SC + 5) @(posedge pclk);
    pulse(0);
    pulse(0);
    repeat (4) @(posedge pclk);
    pins(33'h0, 33'h40);
    for (int k = 0; k < 6; k++) begin
      pulse(k);
      repeat (3) @(posedge pclk);
      pins(33'h40, 33'h40);
      repeat (SC + 5) @(posedge pclk);
      pins({25'(SC), 8'h00}, {25'h1ff_ffff, 8'h40});
    end
    // A lasting self-test failure holds the alarm until the next reset.
    hold_fail <= 1'b1;
    @(posedge pclk);
    hold_fail <= 1'b0;
    repeat (SC + 10) @(posedge pclk);
    pins(33'h40, 33'h40);
    rd(REG_TGT, 33'h80, 33'hc0);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    ticks(2);
    pins(33'h0, 33'hff);
    rd(REG_TGT, 33'h40, '1);
    end_of_test();
  end
endmodule // rwl_relay_logic_tb_top
`default_nettype wire
